// *** design/tcc_channels.sv ***
// Two capture/compare channels of a 16-bit timer with an APB register slave.
`timescale 1ns/10ps
`include "tcc_consts.svh"
module tcc_channels
  import tcc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [15:0] counter_value_in,
  input wire logic counter_overflow_in,
  input wire logic counter_halt_in,
  input wire logic [1:0] channel_pin_in,
  output logic [1:0] channel_pin_out,
  output logic [1:0] channel_pin_oe_out,
  output logic [1:0] channel_pin_owned_out,
  output logic [1:0] channel_irq_out
);
  localparam logic [2:0] IDX_CTRL [2] = '{`TCC_IDX_CTRL0, `TCC_IDX_CTRL1};
  localparam logic [2:0] IDX_VALH [2] = '{`TCC_IDX_VALH0, `TCC_IDX_VALH1};
  localparam logic [2:0] IDX_VALL [2] = '{`TCC_IDX_VALL0, `TCC_IDX_VALL1};

  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      `TCC_OFS_CTRL0: reg_index = `TCC_IDX_CTRL0;
      `TCC_OFS_CTRL1: reg_index = `TCC_IDX_CTRL1;
      `TCC_OFS_VALH0: reg_index = `TCC_IDX_VALH0;
      `TCC_OFS_VALL0: reg_index = `TCC_IDX_VALL0;
      `TCC_OFS_VALH1: reg_index = `TCC_IDX_VALH1;
      `TCC_OFS_VALL1: reg_index = `TCC_IDX_VALL1;
      default: reg_index = `TCC_IDX_NONE;
    endcase
  endfunction

  // Channel 1 passes buf_ok low, so only channel 0 can enter buffered mode.
  function automatic tcc_mode_t mode_of(input tcc_ctrl_t c, input logic buf_ok);
    if (c.els == 2'b00) begin
      mode_of = TCC_MODE_PRESET;
    end else if (buf_ok && c.buf_sel) begin
      mode_of = TCC_MODE_BUFCMP;
    end else if (c.unbuf_sel) begin
      mode_of = TCC_MODE_CMP;
    end else begin
      mode_of = TCC_MODE_CAPTURE;
    end
  endfunction

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [1:0] pin_sync;
  tcc_edges_t pin_edges [2];
  tcc_edges_t match_edges [2];
  tcc_apb_state_t apb_state;
  logic apb_take;
  logic rd_stb;
  logic wr_stb;
  logic [2:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rdata;
  tcc_ctrl_t ctrl [2];
  logic [15:0] val [2];
  logic [1:0] clr_armed;
  logic [1:0] rd_lock;
  logic [1:0] wr_lock;
  logic [1:0] max_eff;
  logic [1:0] max_now;
  logic buf_active;
  logic buf_pending;
  tcc_mode_t mode [2];
  logic [15:0] cmp_val [2];
  logic [1:0] match_now;
  logic [1:0] cmp_blocked;
  logic [1:0] is_compare;
  logic [1:0] sw_compare;
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;

  // Reset is applied at once and released through two flops.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  tcc_sync #(
    .W(2)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .async_in(channel_pin_in),
    .sync_out(pin_sync)
  );

  for (genvar g = 0; g < 2; g++) begin : g_edges
    tcc_edge u_pin_edge (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .level_in(pin_sync[g]),
      .edges_out(pin_edges[g])
    );
    // A match lasts for a whole prescaled count; only its start is an event.
    tcc_edge u_match_edge (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .level_in(match_now[g]),
      .edges_out(match_edges[g])
    );
  end

  // APB slave: the access is taken once, pready follows one cycle later.
  assign apb_take = psel_in && penable_in && (apb_state == TCC_APB_IDLE);
  assign rd_stb = apb_take && !pwrite_in;
  assign wr_stb = apb_take && pwrite_in;
  assign idx = reg_index(paddr_in);
  assign wbyte = pwdata_in[7:0];

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      apb_state <= TCC_APB_IDLE;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      case (apb_state)
        TCC_APB_IDLE: begin
          if (apb_take) begin
            apb_state <= TCC_APB_DONE;
            pready_out <= 1'b1;
            pslverr_out <= (idx == `TCC_IDX_NONE);
            prdata_out <= {24'h00_0000, pwrite_in ? 8'h00 : rdata};
          end
        end
        TCC_APB_DONE: begin
          apb_state <= TCC_APB_IDLE;
          pready_out <= 1'b0;
          pslverr_out <= 1'b0;
        end
        default: begin
          apb_state <= TCC_APB_IDLE;
          pready_out <= 1'b0;
          pslverr_out <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    case (idx)
      `TCC_IDX_CTRL0: rdata = ctrl[0];
      `TCC_IDX_CTRL1: rdata = ctrl[1];
      `TCC_IDX_VALH0: rdata = val[0][15:8];
      `TCC_IDX_VALL0: rdata = val[0][7:0];
      `TCC_IDX_VALH1: rdata = val[1][15:8];
      `TCC_IDX_VALL1: rdata = val[1][7:0];
      default: rdata = `TCC_UNMAPPED_DATA;
    endcase
  end

  // Channel decode and event detection.
  always_comb begin
    mode[0] = mode_of(ctrl[0], 1'b1);
    // While channel 0 is buffered, channel 1 settings are not looked at.
    mode[1] = ctrl[0].buf_sel ? TCC_MODE_OFF : mode_of(ctrl[1], 1'b0);
    cmp_val[0] = (mode[0] == TCC_MODE_BUFCMP) ? val[buf_active] : val[0];
    cmp_val[1] = val[1];
    cmp_blocked[0] = (mode[0] == TCC_MODE_BUFCMP) ? wr_lock[buf_active] : wr_lock[0];
    cmp_blocked[1] = wr_lock[1];
    for (int i = 0; i < 2; i++) begin
      match_now[i] = (counter_value_in == cmp_val[i]);
      is_compare[i] = (mode[i] == TCC_MODE_CMP) || (mode[i] == TCC_MODE_BUFCMP);
      // Unbuffered bit with buf_sel clear and a zero edge field still flags matches in software.
      sw_compare[i] = (mode[i] == TCC_MODE_PRESET) && ctrl[i].unbuf_sel && !ctrl[i].buf_sel;
      cap_evt[i] = (mode[i] == TCC_MODE_CAPTURE) && !counter_halt_in && !rd_lock[i] &&
                   ((ctrl[i].els[0] && pin_edges[i].rise) || (ctrl[i].els[1] && pin_edges[i].fall));
      cmp_evt[i] = match_edges[i].rise && !cmp_blocked[i] && (is_compare[i] || sw_compare[i]);
      // At an overflow the period that starts already follows the new full-duty bit.
      max_now[i] = counter_overflow_in ? ctrl[i].max : max_eff[i];
    end
  end

  // Control registers and the event flag.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl[0] <= `TCC_CTRL_RESET;
      ctrl[1] <= `TCC_CTRL_RESET;
      clr_armed <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rd_stb && idx == IDX_CTRL[i] && ctrl[i].flag) begin
          clr_armed[i] <= 1'b1;
        end
        if (wr_stb && idx == IDX_CTRL[i]) begin
          ctrl[i].irq_en <= wbyte[`TCC_BIT_IRQ_EN];
          ctrl[i].buf_sel <= (i == 0) ? wbyte[`TCC_BIT_BUF_SEL] : 1'b0;
          ctrl[i].unbuf_sel <= wbyte[`TCC_BIT_UNBUF_SEL];
          ctrl[i].els <= {wbyte[`TCC_BIT_ELS_HI], wbyte[`TCC_BIT_ELS_LO]};
          ctrl[i].tov <= wbyte[`TCC_BIT_TOV];
          ctrl[i].max <= wbyte[`TCC_BIT_MAX];
          clr_armed[i] <= 1'b0;
          if (!wbyte[`TCC_BIT_FLAG] && clr_armed[i]) begin
            ctrl[i].flag <= 1'b0;
          end
        end
        // A new event cancels a half-done clear sequence and wins over the clear.
        if (cap_evt[i] || cmp_evt[i]) begin
          ctrl[i].flag <= 1'b1;
          clr_armed[i] <= 1'b0;
        end
      end
    end
  end

  // Value registers keep no reset value.
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_stb && idx == IDX_VALH[i]) begin
        val[i][15:8] <= wbyte;
      end
      if (wr_stb && idx == IDX_VALL[i]) begin
        val[i][7:0] <= wbyte;
      end
      if (cap_evt[i]) begin
        val[i] <= counter_value_in;
      end
    end
  end

  // Byte interlocks on the value registers.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_lock <= 2'b00;
      wr_lock <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rd_stb && idx == IDX_VALH[i] && mode[i] == TCC_MODE_CAPTURE) begin
          rd_lock[i] <= 1'b1;
        end
        if (rd_stb && idx == IDX_VALL[i]) begin
          rd_lock[i] <= 1'b0;
        end
        if (wr_stb && idx == IDX_VALH[i] && mode[i] != TCC_MODE_CAPTURE) begin
          wr_lock[i] <= 1'b1;
        end
        if (wr_stb && idx == IDX_VALL[i]) begin
          wr_lock[i] <= 1'b0;
        end
      end
    end
  end

  // Period-boundary state: buffer swap and the full-duty latch.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      buf_active <= 1'b0;
      buf_pending <= 1'b0;
      max_eff <= 2'b00;
    end else begin
      if (mode[0] == TCC_MODE_BUFCMP && wr_stb && idx == `TCC_IDX_VALL0) begin
        buf_pending <= 1'b0;
      end
      if (mode[0] == TCC_MODE_BUFCMP && wr_stb && idx == `TCC_IDX_VALL1) begin
        buf_pending <= 1'b1;
      end
      if (counter_overflow_in) begin
        buf_active <= buf_pending;
        max_eff <= {ctrl[1].max, ctrl[0].max};
      end
    end
  end

  // Pin level, ownership and drive.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      channel_pin_out <= 2'b00;
      channel_pin_oe_out <= 2'b00;
      channel_pin_owned_out <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        channel_pin_owned_out[i] <= is_compare[i] || (mode[i] == TCC_MODE_CAPTURE);
        channel_pin_oe_out[i] <= is_compare[i];
        case (mode[i])
          TCC_MODE_PRESET: begin
            channel_pin_out[i] <= !ctrl[i].unbuf_sel;
          end
          TCC_MODE_CMP, TCC_MODE_BUFCMP: begin
            if (ctrl[i].tov && max_now[i]) begin
              channel_pin_out[i] <= 1'b1;
            end else if (counter_overflow_in && ctrl[i].tov) begin
              channel_pin_out[i] <= !channel_pin_out[i];
            end else if (cmp_evt[i]) begin
              case (ctrl[i].els)
                `TCC_ELS_TOGGLE: channel_pin_out[i] <= !channel_pin_out[i];
                `TCC_ELS_CLEAR: channel_pin_out[i] <= 1'b0;
                `TCC_ELS_SET: channel_pin_out[i] <= 1'b1;
                default: channel_pin_out[i] <= channel_pin_out[i];
              endcase
            end
          end
          default: begin
            channel_pin_out[i] <= channel_pin_out[i];
          end
        endcase
      end
    end
  end

  // Interrupt requests follow flag and enable one cycle later.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      channel_irq_out <= 2'b00;
    end else begin
      channel_irq_out[0] <= ctrl[0].flag && ctrl[0].irq_en;
      channel_irq_out[1] <= ctrl[1].flag && ctrl[1].irq_en;
    end
  end
endmodule // tcc_channels

// *** design/tcc_consts.svh ***
// Register map, field positions, reset values and decode codes of the capture/compare channels.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_OFS_CTRL0 8'h00
`define TCC_OFS_CTRL1 8'h04
`define TCC_OFS_VALH0 8'h08
`define TCC_OFS_VALL0 8'h0c
`define TCC_OFS_VALH1 8'h10
`define TCC_OFS_VALL1 8'h14
`define TCC_IDX_CTRL0 3'h0
`define TCC_IDX_CTRL1 3'h1
`define TCC_IDX_VALH0 3'h2
`define TCC_IDX_VALL0 3'h3
`define TCC_IDX_VALH1 3'h4
`define TCC_IDX_VALL1 3'h5
`define TCC_IDX_NONE 3'h7
`define TCC_BIT_FLAG 7
`define TCC_BIT_IRQ_EN 6
`define TCC_BIT_BUF_SEL 5
`define TCC_BIT_UNBUF_SEL 4
`define TCC_BIT_ELS_HI 3
`define TCC_BIT_ELS_LO 2
`define TCC_BIT_TOV 1
`define TCC_BIT_MAX 0
`define TCC_CTRL_RESET 8'h00
`define TCC_ELS_TOGGLE 2'h1
`define TCC_ELS_CLEAR 2'h2
`define TCC_ELS_SET 2'h3
`define TCC_UNMAPPED_DATA 8'h00
`endif

// *** design/tcc_edge.sv ***
// Rising and falling edge pulses of a synchronous level, one cycle each.
`timescale 1ns/10ps
module tcc_edge
  import tcc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic level_in,
  output tcc_edges_t edges_out
);
  logic level_prev;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level_in;
    end
  end

  assign edges_out.rise = level_in && !level_prev;
  assign edges_out.fall = !level_in && level_prev;
endmodule // tcc_edge

// *** design/tcc_pkg.sv ***
// Types shared by the capture/compare channel design.
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_MODE_PRESET = 3'b000,
    TCC_MODE_CAPTURE = 3'b001,
    TCC_MODE_CMP = 3'b010,
    TCC_MODE_BUFCMP = 3'b011,
    TCC_MODE_OFF = 3'b100
  } tcc_mode_t;

  typedef enum logic {
    TCC_APB_IDLE = 1'b0,
    TCC_APB_DONE = 1'b1
  } tcc_apb_state_t;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buf_sel;
    logic unbuf_sel;
    logic [1:0] els;
    logic tov;
    logic max;
  } tcc_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } tcc_edges_t;
endpackage

// *** design/tcc_sync.sv ***
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/10ps
module tcc_sync #(
  parameter int W = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // tcc_sync

// *** test/tcc_channels_monitor.sv ***
// Port checker for the capture/compare channel block.
`timescale 1ns/10ps
module tcc_channels_monitor (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic counter_overflow_in,
  input wire logic [1:0] channel_pin_out,
  input wire logic [1:0] channel_pin_oe_out,
  input wire logic [1:0] channel_pin_owned_out,
  input wire logic [1:0] channel_irq_out
);
  logic [7:0] ctl0;
  logic bad;
  assign bad = paddr_in > 8'h14 || paddr_in[1:0] != 2'h0;
  // Shadow of channel 0 control, updated at the edge that takes a write.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl0 <= 8'h00;
    end else if (psel_in && penable_in && !pready_out && pwrite_in && paddr_in == 8'h00) begin
      ctl0 <= pwdata_in[7:0];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence apb_take_s;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence cmp_cfg_s;
    (ctl0[5:4] == 2'b01 && ctl0[3:2] != 2'h0 && ctl0[1:0] == 2'b10) [*3];
  endsequence
  apb_answer_a: assert property (apb_take_s |=> pready_out ##1 !pready_out)
    else $error("pready not a single pulse after take");
  slverr_map_a: assert property (apb_take_s |=> pslverr_out == $past(bad))
    else $error("pslverr does not match address decode");
  rdata_clean_a: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0 && (!pslverr_out || prdata_out == 32'h0))
    else $error("read data upper bits or error data wrong");
  oe_owned_a: assert property ((channel_pin_oe_out & ~channel_pin_owned_out) == 2'b00)
    else $error("pin driven while not owned");
  irq_mask_a: assert property (!ctl0[6] [*3] |-> !channel_irq_out[0])
    else $error("irq while enable low");
  preset_level_a: assert property ((ctl0[3:2] == 2'h0 && $stable(ctl0[4])) [*5] |-> channel_pin_out[0] == !ctl0[4])
    else $error("preset level wrong");
  disconnect_a: assert property ((ctl0[3:2] == 2'h0) [*3] |-> !channel_pin_owned_out[0] && !channel_pin_oe_out[0])
    else $error("pin held with zero edge field");
  capture_own_a: assert property ((ctl0[5:4] == 2'b00 && ctl0[3:2] != 2'h0) [*3] |-> channel_pin_owned_out[0] && !channel_pin_oe_out[0])
    else $error("capture pin ownership wrong");
  buf_release_a: assert property (ctl0[5] [*3] |-> !channel_pin_owned_out[1] && !channel_pin_oe_out[1])
    else $error("channel 1 pin kept in buffered mode");
  ovf_toggle_a: assert property (cmp_cfg_s ##0 counter_overflow_in |=> channel_pin_out[0] != $past(channel_pin_out[0]))
    else $error("no toggle on overflow");
endmodule // tcc_channels_monitor
bind tcc_channels tcc_channels_monitor mon_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .counter_overflow_in(counter_overflow_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe_out(channel_pin_oe_out),
  .channel_pin_owned_out(channel_pin_owned_out), .channel_irq_out(channel_irq_out));

// *** test/tcc_pin_model.sv ***
// External signal source that shares the two channel pins with the timer.
`timescale 1ns/10ps
module tcc_pin_model (
  input wire logic [1:0] level_in,
  input wire logic [1:0] oe_in,
  input wire logic [1:0] out_in,
  output logic [1:0] pin_out
);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_out[i] = oe_in[i] ? out_in[i] : level_in[i];
    end
  end
endmodule // tcc_pin_model

// *** test/timer_channel_capture_compare_bench.sv ***
// Self-checking bench for the capture/compare channels.
`timescale 1ns/10ps
module timer_channel_capture_compare_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ovf = 1'b0, halt = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, re;
  logic [15:0] cnt = 16'h0;
  logic [1:0] lvl = 2'b00, pin, pout, oe, owned, irq;
  int err_total = 0, check_count = 0;
  always #50 core_clk = ~core_clk;
  tcc_channels dut_u (.core_clk_in(core_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .counter_value_in(cnt), .counter_overflow_in(ovf), .counter_halt_in(halt),
    .channel_pin_in(pin), .channel_pin_out(pout), .channel_pin_oe_out(oe), .channel_pin_owned_out(owned),
    .channel_irq_out(irq));
  tcc_pin_model pm_u (.level_in(lvl), .oe_in(oe), .out_in(pout), .pin_out(pin));
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse_ovf();
    ovf <= 1'b1;
    @(posedge core_clk);
    ovf <= 1'b0;
    wt(2);
  endtask
  task automatic t_reset();
    rd(8'h00);
    chk("ctrl0", 32'h0, rv);
    chk("preset pins", 2'b11, pout);
    chk("owned", 2'b00, owned);
    wr(8'h00, 8'h10);
    wt(1);
    chk("preset low", 2'b10, pout);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h20);
    cnt <= 16'h0020;
    rd(8'h00);
    chk("sw cmp flag", 32'h90, rv);
    chk("sw cmp pin", 1'b0, pout[0]);
    chk("sw cmp owned", 1'b0, owned[0]);
    rd(8'h18);
    chk("slverr", 1'b1, re);
    chk("bad rdata", 32'h0, rv);
    $display("test reset done");
  endtask
  task automatic t_capture();
    wr(8'h00, 8'h44);
    rd(8'h00);
    wr(8'h00, 8'h44);
    rd(8'h00);
    chk("setup flag", 32'h44, rv);
    cnt <= 16'h1234;
    lvl <= 2'b01;
    wt(8);
    rd(8'h00);
    chk("cap flag", 32'hc4, rv);
    chk("irq", 2'b01, irq);
    rd(8'h08);
    chk("cap high", 32'h12, rv);
    cnt <= 16'h5678;
    lvl <= 2'b00;
    wt(8);
    lvl <= 2'b01;
    wt(8);
    rd(8'h0c);
    chk("cap low", 32'h34, rv);
    rd(8'h00);
    wr(8'h00, 8'h44);
    lvl <= 2'b00;
    wt(8);
    rd(8'h00);
    chk("flag cleared", 32'h44, rv);
    chk("irq off", 2'b00, irq);
    halt <= 1'b1;
    lvl <= 2'b01;
    wt(8);
    rd(8'h00);
    chk("halted", 32'h44, rv);
    halt <= 1'b0;
    wr(8'h00, 8'h08);
    lvl <= 2'b00;
    wt(8);
    rd(8'h00);
    chk("fall flag", 32'h88, rv);
    chk("irq masked", 2'b00, irq);
    $display("test capture done");
  endtask
  task automatic t_compare();
    logic p, e;
    halt <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      cnt <= 16'h0000;
      wr(8'h00, 8'(16 + 4 * k));
      wr(8'h08, 8'h00);
      wr(8'h0c, 8'h40);
      halt <= 1'b0;
      p = pout[0];
      e = (k == 1) ? !p : (k == 3);
      cnt <= 16'h0040;
      wt(3);
      chk("cmp pin", e, pout[0]);
    end
    chk("cmp oe", 1'b1, oe[0]);
    cnt <= 16'h0000;
    wr(8'h00, 8'h18);
    wr(8'h08, 8'h00);
    cnt <= 16'h0040;
    wt(3);
    chk("locked", 1'b1, pout[0]);
    wr(8'h0c, 8'h40);
    cnt <= 16'h0000;
    wt(1);
    cnt <= 16'h0040;
    wt(3);
    chk("unlocked", 1'b0, pout[0]);
    $display("test compare done");
  endtask
  task automatic t_tov();
    cnt <= 16'h0000;
    wr(8'h00, 8'h1e);
    pulse_ovf();
    chk("ovf tog", 1'b1, pout[0]);
    cnt <= 16'h0040;
    pulse_ovf();
    wt(1);
    chk("ovf wins", 1'b0, pout[0]);
    wr(8'h00, 8'h17);
    pulse_ovf();
    chk("max on", 1'b1, pout[0]);
    cnt <= 16'h0000;
    wt(1);
    cnt <= 16'h0040;
    wt(3);
    chk("max hold", 1'b1, pout[0]);
    wr(8'h00, 8'h16);
    cnt <= 16'h0000;
    wt(1);
    cnt <= 16'h0040;
    wt(3);
    chk("max late", 1'b1, pout[0]);
    pulse_ovf();
    chk("max off", 1'b0, pout[0]);
    $display("test overflow done");
  endtask
  task automatic t_buffered();
    wr(8'h04, 8'h34);
    rd(8'h04);
    chk("ctrl1 buf", 32'h14, rv);
    wr(8'h00, 8'h2c);
    wt(2);
    chk("ch1 owned", 1'b0, owned[1]);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h80);
    cnt <= 16'h0000;
    pulse_ovf();
    cnt <= 16'h0080;
    wt(3);
    chk("buf set", 1'b1, pout[0]);
    wr(8'h00, 8'h28);
    cnt <= 16'h0000;
    wt(1);
    cnt <= 16'h0080;
    wt(3);
    chk("buf clear", 1'b0, pout[0]);
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h2c);
    cnt <= 16'h0000;
    pulse_ovf();
    cnt <= 16'h0080;
    wt(3);
    chk("buf old", 1'b0, pout[0]);
    cnt <= 16'h0100;
    wt(3);
    chk("buf swap", 1'b1, pout[0]);
    $display("test buffered done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    wt(20000);
    err_total++;
    $display("ERROR watchdog expected done seen timeout");
    give_verdict();
  end
  initial begin
    wt(6);
    rst_n <= 1'b1;
    wt(3);
    t_reset();
    t_capture();
    t_compare();
    t_tov();
    t_buffered();
    give_verdict();
  end
endmodule // timer_channel_capture_compare_bench
